// >>> common/dpdmp_pkg.sv
// package: register map, field layout and reset values of the damping registers
`default_nettype none
package dpdmp_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] T4_DAMP_OFS = 8'h6A;
	localparam logic [7:0] MON_DAMP_OFS = 8'h6B;
	localparam logic [7:0] DAMP_RST = 8'h13;
	localparam logic [2:0] FIXED_FIELD = 3'h1;
	localparam int CODE_LSB = 0;
	localparam int FIXED_LSB = 4;
	localparam logic [2:0] CODE_MIN = 3'h1;
	localparam logic [2:0] CODE_MAX = 3'h5;
	localparam logic [2:0] CODE_DEF = 3'h3;
	typedef enum logic [1:0]
	{
		PD2_GAIN_FIXED = 2'b00,
		PD2_GAIN_FROM_MON = 2'b01
	} dpdmp_pd2_mode_t;
endpackage
`default_nettype wire

// >>> rtl/dpdmp_code_reg.sv
// one damping register: 3-bit code with fixed field and unused bits
`default_nettype none
module dpdmp_code_reg
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	output logic [7:0] reg_value,
	output logic [2:0] code,
	output logic code_valid
);
	logic [7:0] val_r;
	logic [7:0] val_nxt;

	always_comb
	begin
		val_nxt = val_r;
		if (wr_en)
		begin
			val_nxt = wr_data;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			val_r <= dpdmp_pkg::DAMP_RST;
		end
		else
		begin
			val_r <= val_nxt;
		end
	end

	assign reg_value = val_r;
	assign code = val_r[dpdmp_pkg::CODE_LSB +: 3];
	assign code_valid = (code >= dpdmp_pkg::CODE_MIN) && (code <= dpdmp_pkg::CODE_MAX);

	a_reset_value: assert property (@(posedge clk)
		sys_rst |=> val_r == dpdmp_pkg::DAMP_RST)
		else $error("damping register not at default after reset");
	a_write_store: assert property (@(posedge clk) disable iff (sys_rst)
		wr_en |=> val_r == $past(wr_data))
		else $error("write not stored");
	a_hold_value: assert property (@(posedge clk) disable iff (sys_rst)
		!wr_en |=> $stable(val_r))
		else $error("register changed without write");
endmodule
`default_nettype wire

// >>> rtl/dpdmp_pd2_gain.sv
// second phase detector gain selection from monitor damping code
`default_nettype none
module dpdmp_pd2_gain
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic gain_from_mon,
	input wire logic [2:0] mon_code,
	input wire logic mon_valid,
	output logic [2:0] pd2_gain_code
);
	logic [2:0] gain_r;
	logic [2:0] gain_nxt;

	always_comb
	begin
		gain_nxt = dpdmp_pkg::CODE_DEF;
		if (gain_from_mon && mon_valid)
		begin
			gain_nxt = mon_code;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			gain_r <= dpdmp_pkg::CODE_DEF;
		end
		else
		begin
			gain_r <= gain_nxt;
		end
	end

	assign pd2_gain_code = gain_r;

	a_gain_follow: assert property (@(posedge clk) disable iff (sys_rst)
		(gain_from_mon && mon_valid) |=> pd2_gain_code == $past(mon_code))
		else $error("pd2 gain not following monitor code");
	a_gain_default: assert property (@(posedge clk) disable iff (sys_rst)
		!gain_from_mon |=> pd2_gain_code == dpdmp_pkg::CODE_DEF)
		else $error("pd2 gain not default outside gain mode");
endmodule
`default_nettype wire

// >>> rtl/dpdmp_regs.sv
// damping configuration register bank for the extra path and monitor loops
`default_nettype none
module dpdmp_regs
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rdata,
	input wire logic gain_from_mon,
	output logic [2:0] extra_path_damping_code,
	output logic extra_path_code_valid,
	output logic [2:0] monitor_loop_damping_code,
	output logic monitor_code_valid,
	output logic [2:0] pd2_gain_code
);
	logic [7:0] t4_val;
	logic [7:0] mon_val;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic t4_wr;
	logic mon_wr;

	// decoding shared by writes and reads
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	assign t4_wr = wr_stb && hit(addr, dpdmp_pkg::T4_DAMP_OFS);
	assign mon_wr = wr_stb && hit(addr, dpdmp_pkg::MON_DAMP_OFS);

	dpdmp_code_reg u_t4
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.wr_en(t4_wr),
		.wr_data(wdata),
		.reg_value(t4_val),
		.code(extra_path_damping_code),
		.code_valid(extra_path_code_valid)
	);

	dpdmp_code_reg u_mon
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.wr_en(mon_wr),
		.wr_data(wdata),
		.reg_value(mon_val),
		.code(monitor_loop_damping_code),
		.code_valid(monitor_code_valid)
	);

	dpdmp_pd2_gain u_gain
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.gain_from_mon(gain_from_mon),
		.mon_code(monitor_loop_damping_code),
		.mon_valid(monitor_code_valid),
		.pd2_gain_code(pd2_gain_code)
	);

	always_comb
	begin
		rdata_nxt = 8'h00;
		if (rd_stb)
		begin
			if (hit(addr, dpdmp_pkg::T4_DAMP_OFS))
			begin
				rdata_nxt = t4_val;
			end
			else if (hit(addr, dpdmp_pkg::MON_DAMP_OFS))
			begin
				rdata_nxt = mon_val;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rdata_r <= 8'h00;
		end
		else
		begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata = rdata_r;

	// validity decode shared by several checks
	function automatic logic code_ok(input logic [2:0] c);
		code_ok = (c >= dpdmp_pkg::CODE_MIN) && (c <= dpdmp_pkg::CODE_MAX);
	endfunction

	// shadow of the last byte written to each place, kept apart from the cells
	// so that a fault inside a cell cannot hide behind its own read path
	logic [7:0] t4_shadow_r;
	logic [7:0] t4_shadow_nxt;
	logic [7:0] mon_shadow_r;
	logic [7:0] mon_shadow_nxt;

	always_comb
	begin
		t4_shadow_nxt = t4_shadow_r;
		mon_shadow_nxt = mon_shadow_r;
		if (wr_stb && addr == dpdmp_pkg::T4_DAMP_OFS)
		begin
			t4_shadow_nxt = wdata;
		end
		if (wr_stb && addr == dpdmp_pkg::MON_DAMP_OFS)
		begin
			mon_shadow_nxt = wdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			t4_shadow_r <= dpdmp_pkg::DAMP_RST;
			mon_shadow_r <= dpdmp_pkg::DAMP_RST;
		end
		else
		begin
			t4_shadow_r <= t4_shadow_nxt;
			mon_shadow_r <= mon_shadow_nxt;
		end
	end

	sequence s_mon_read;
		rd_stb && hit(addr, dpdmp_pkg::MON_DAMP_OFS);
	endsequence

	sequence s_t4_read;
		rd_stb && hit(addr, dpdmp_pkg::T4_DAMP_OFS);
	endsequence

	sequence s_mon_write;
		wr_stb && hit(addr, dpdmp_pkg::MON_DAMP_OFS);
	endsequence

	sequence s_t4_write;
		wr_stb && hit(addr, dpdmp_pkg::T4_DAMP_OFS);
	endsequence

	// a strobe to any other place must leave both registers and the read port alone
	sequence s_other_read;
		rd_stb && !hit(addr, dpdmp_pkg::T4_DAMP_OFS) && !hit(addr, dpdmp_pkg::MON_DAMP_OFS);
	endsequence

	sequence s_other_write;
		wr_stb && !hit(addr, dpdmp_pkg::T4_DAMP_OFS) && !hit(addr, dpdmp_pkg::MON_DAMP_OFS);
	endsequence

	// read port: data only in the cycle after a strobe, zero elsewhere
	a_mon_readback: assert property (@(posedge clk) disable iff (sys_rst)
		s_mon_read
		|=> rdata == $past(mon_val))
		else $error("monitor register readback wrong");

	a_t4_readback: assert property (@(posedge clk) disable iff (sys_rst)
		s_t4_read
		|=> rdata == $past(t4_val))
		else $error("extra path register readback wrong");

	a_read_idle: assert property (@(posedge clk) disable iff (sys_rst)
		!rd_stb
		|=> rdata == 8'h00)
		else $error("read data not cleared outside a read");

	a_unmapped_read: assert property (@(posedge clk) disable iff (sys_rst)
		s_other_read
		|=> rdata == 8'h00)
		else $error("unmapped read returned data");

	a_write_read: assert property (@(posedge clk) disable iff (sys_rst)
		s_mon_write ##1 s_mon_read
		|=> rdata == $past(wdata, 2))
		else $error("write then read mismatch");

	a_t4_write_read: assert property (@(posedge clk) disable iff (sys_rst)
		s_t4_write ##1 s_t4_read
		|=> rdata == $past(wdata, 2))
		else $error("extra path write then read mismatch");

	// reset values; the read port clears too, so a stale byte never leaks out
	a_rdata_reset: assert property (@(posedge clk)
		sys_rst
		|=> rdata == 8'h00)
		else $error("read data not cleared by reset");

	a_mon_default: assert property (@(posedge clk)
		$fell(sys_rst)
		|-> monitor_loop_damping_code == dpdmp_pkg::CODE_DEF
			&& mon_val == dpdmp_pkg::DAMP_RST)
		else $error("monitor default code wrong");

	a_mon_fixed: assert property (@(posedge clk)
		$fell(sys_rst)
		|-> mon_val[dpdmp_pkg::FIXED_LSB +: 3] == dpdmp_pkg::FIXED_FIELD)
		else $error("monitor fixed field wrong after reset");

	a_t4_default: assert property (@(posedge clk)
		$fell(sys_rst)
		|-> extra_path_damping_code == dpdmp_pkg::CODE_DEF
			&& t4_val == dpdmp_pkg::DAMP_RST)
		else $error("extra path default code wrong");

	// code fields follow the stored byte
	a_code_valid: assert property (@(posedge clk) disable iff (sys_rst)
		monitor_code_valid == (monitor_loop_damping_code inside {[dpdmp_pkg::CODE_MIN:dpdmp_pkg::CODE_MAX]}))
		else $error("monitor code validity wrong");

	a_t4_valid: assert property (@(posedge clk) disable iff (sys_rst)
		extra_path_code_valid == code_ok(extra_path_damping_code))
		else $error("extra path code validity wrong");

	a_mon_field: assert property (@(posedge clk) disable iff (sys_rst)
		monitor_loop_damping_code == mon_val[dpdmp_pkg::CODE_LSB +: 3])
		else $error("monitor code not taken from its field");

	a_t4_field: assert property (@(posedge clk) disable iff (sys_rst)
		extra_path_damping_code == t4_val[dpdmp_pkg::CODE_LSB +: 3])
		else $error("extra path code not taken from its field");

	// gain path: follows a valid monitor code one cycle later, default otherwise
	a_gain_invalid: assert property (@(posedge clk) disable iff (sys_rst)
		(gain_from_mon && !monitor_code_valid)
		|=> pd2_gain_code == dpdmp_pkg::CODE_DEF)
		else $error("pd2 gain not default for an unused code");

	a_gain_lag: assert property (@(posedge clk) disable iff (sys_rst)
		s_mon_write ##1 (gain_from_mon && code_ok(monitor_loop_damping_code))
		|=> pd2_gain_code == $past(wdata[2:0], 2))
		else $error("pd2 gain did not take the written code");

	// write isolation: a byte lands in one place only
	a_t4_isolate: assert property (@(posedge clk) disable iff (sys_rst)
		s_mon_write
		|=> $stable(t4_val))
		else $error("monitor write disturbed extra path register");

	a_mon_isolate: assert property (@(posedge clk) disable iff (sys_rst)
		s_t4_write
		|=> $stable(mon_val))
		else $error("extra path write disturbed monitor register");

	a_unmapped_write: assert property (@(posedge clk) disable iff (sys_rst)
		s_other_write
		|=> $stable(t4_val) && $stable(mon_val))
		else $error("unmapped write changed a register");

	// cells agree with the shadow of what was written
	a_t4_shadow: assert property (@(posedge clk) disable iff (sys_rst)
		t4_val == t4_shadow_r)
		else $error("extra path register lost its byte");

	a_mon_shadow: assert property (@(posedge clk) disable iff (sys_rst)
		mon_val == mon_shadow_r)
		else $error("monitor register lost its byte");

	// per-register view, so both places are held to the same read and write checks
	logic [7:0] slot_val [2];
	logic [7:0] slot_ofs [2];

	assign slot_val[0] = t4_val;
	assign slot_val[1] = mon_val;
	assign slot_ofs[0] = dpdmp_pkg::T4_DAMP_OFS;
	assign slot_ofs[1] = dpdmp_pkg::MON_DAMP_OFS;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_slot
			a_slot_write: assert property (@(posedge clk) disable iff (sys_rst)
				(wr_stb && addr == slot_ofs[g]) |=> slot_val[g] == $past(wdata))
				else $error("register did not take the written byte");
			a_slot_read: assert property (@(posedge clk) disable iff (sys_rst)
				(rd_stb && addr == slot_ofs[g]) |=> rdata == $past(slot_val[g]))
				else $error("register readback wrong");
		end
	endgenerate
endmodule
`default_nettype wire

// >>> tb/dpdmp_regs_test.sv
// bench for the damping register bank
`default_nettype none
module dpdmp_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0;
	logic sys_rst = 1;
	logic wr_stb = 0;
	logic rd_stb = 0;
	logic gfm = 0;
	logic rd_q = 0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [7:0] exp_q[$];
	logic [2:0] ep_c, mon_c, pd2;
	logic ep_v, mon_v, v;
	logic [31:0] r;
	int fails = 0;
	int checks = 0;
	dpdmp_regs dpdmp_regs_i (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .gain_from_mon(gfm),
		.extra_path_damping_code(ep_c), .extra_path_code_valid(ep_v),
		.monitor_loop_damping_code(mon_c), .monitor_code_valid(mon_v), .pd2_gain_code(pd2));
	initial
	begin
		forever #20 clk = ~clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checks++;
		if (seen !== want)
		begin
			fails++;
			$display("unexpected at %0t: seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask
	// write and read back to back, the read in the cycle right after the write
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
		rd_stb <= 1'b1;
		exp_q.push_back(d);
		@(posedge clk);
		rd_stb <= 1'b0;
	endtask
	// reads are only noted here; the watcher below compares them
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd_stb <= 1'b0;
	endtask
	task automatic complete_run;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// read data stands only in the cycle after the strobe, zero otherwise
	always @(posedge clk)
	begin
		rd_q <= rd_stb;
		// read data is unknown before the first reset edge, so reset cycles are skipped
		if (!sys_rst && rd_q)
			check(rdata, exp_q.pop_front());
		else if (!sys_rst)
			check(rdata, 8'h00);
	end
	initial
	begin
		r = $urandom(41333);
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		rd(8'h6B, dpdmp_pkg::DAMP_RST);
		rd(8'h6A, dpdmp_pkg::DAMP_RST);
		@(negedge clk);
		check({5'h00, mon_c}, {5'h00, dpdmp_pkg::CODE_DEF});
		check({5'h00, pd2}, {5'h00, dpdmp_pkg::CODE_DEF});
		$display("test reset done");
		// every code, gain follows only valid ones
		gfm <= 1'b1;
		for (int c = 0; c < 8; c++)
		begin
			wr_rd(8'h6B, {4'h1, 1'b0, c[2:0]});
			@(negedge clk);
			v = (c >= 1 && c <= 5);
			check({5'h00, mon_c}, {5'h00, c[2:0]});
			check({7'h00, mon_v}, {7'h00, v});
			check({5'h00, pd2}, v ? {5'h00, c[2:0]} : {5'h00, dpdmp_pkg::CODE_DEF});
		end
		gfm <= 1'b0;
		wr(8'h6B, 8'h15);
		repeat (2) @(negedge clk);
		check({5'h00, pd2}, {5'h00, dpdmp_pkg::CODE_DEF});
		$display("test monitor codes done");
		// random byte on the extra path register, unmapped place ignored
		r = $urandom;
		wr_rd(8'h6A, r[7:0]);
		wr(8'h6C, ~r[7:0]);
		rd(8'h6A, r[7:0]);
		rd(8'h6C, 8'h00);
		rd(8'h6B, 8'h15);
		@(negedge clk);
		check({5'h00, ep_c}, {5'h00, r[2:0]});
		check({7'h00, ep_v}, {7'h00, r[2:0] >= 3'h1 && r[2:0] <= 3'h5});
		$display("test extra path done");
		// second reset in mid-run brings both defaults back
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(8'h6B, dpdmp_pkg::DAMP_RST);
		rd(8'h6A, dpdmp_pkg::DAMP_RST);
		@(negedge clk);
		check({5'h00, ep_c}, {5'h00, dpdmp_pkg::CODE_DEF});
		check({5'h00, mon_c}, {5'h00, dpdmp_pkg::CODE_DEF});
		repeat (2) @(posedge clk);
		check(8'(exp_q.size()), 8'h00);
		$display("test second reset done");
		complete_run();
	end
endmodule
`default_nettype wire
